// ---- hw/itwc_top.sv ----
// i2c level select, control channel watchdog, forwarding filter and scl timing
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
module itwc_top #(
  parameter int WD_STEP_CYC = itwc_pkg::WD_STEP_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic [itwc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [itwc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [itwc_pkg::DATA_W-1:0] reg_rdata,
  output logic                             irq,
  input  wire logic                        level_strap_pin,
  output logic                             level_sel_3v3,
  input  wire logic                        chan_busy,
  output logic                             chan_abort,
  input  wire logic                        acc_valid,
  input  wire logic [6:0]                  acc_id,
  input  wire logic [6:0]                  ser_id,
  input  wire logic [6:0]                  des_id,
  input  wire logic [6:0]                  rslave_id,
  output logic                             fwd_valid,
  input  wire logic                        mst_en,
  input  wire logic                        slv_setup_req,
  output logic                             slv_setup_done,
  input  wire logic                        scl_i,
  input  wire logic                        sda_i,
  output logic                             scl_o,
  output logic                             scl_oe,
  output logic                             scl_filt,
  output logic                             sda_held
);

  localparam int WDW  = $clog2(WD_STEP_CYC);
  localparam int TAPS = itwc_pkg::HOLD_TAPS;

  if (WD_STEP_CYC < 2) begin : g_bad_step
    $error("watchdog step must be at least 2 cycles");
  end

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic                          lvl;
    logic                          strap_done;
    logic [7:0]                    wdctl;
    logic [7:0]                    fwdctl;
    logic [7:0]                    hi;
    logic [7:0]                    lo;
    logic [itwc_pkg::IRQ_W-1:0]    sts;
    logic [itwc_pkg::IRQ_W-1:0]    msk;
    logic [7:0]                    rdata;
    logic [WDW-1:0]                wd_cyc;
    logic [6:0]                    wd_steps;
    logic                          abort;
    logic                          fwd_valid;
    itwc_pkg::itwc_scl_state_t     st;
    logic [8:0]                    cnt;
    logic                          slv_done;
    logic [TAPS-1:0]               sda_sr;
    logic                          sda_hold;
    logic [11:0]                   len;
  } itwc_st_t;

  itwc_st_t   r;
  itwc_st_t   n;
  logic       osc_tick;
  logic       sda_filt;
  logic [1:0] pin_raw;
  logic [1:0] pin_filt;
  logic [3:0] filt_cyc;
  logic       match;
  logic [6:0] wd_tmo;
  logic [2:0] hold_sel;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // 5 ns steps cannot be met exactly at 8 ns, so the depth rounds up to whole cycles
  function automatic logic [3:0] filt_cycles(input logic [3:0] d);
    int ns;
    ns = int'(d) * itwc_pkg::FILT_STEP_NS;
    return 4'((ns + itwc_pkg::CLK_PERIOD_NS - 1) / itwc_pkg::CLK_PERIOD_NS);
  endfunction

  assign filt_cyc = filt_cycles(r.fwdctl[itwc_pkg::FILT_MSB:itwc_pkg::FILT_LSB]);
  assign wd_tmo   = r.wdctl[itwc_pkg::WD_TMO_MSB:itwc_pkg::WD_TMO_LSB];
  assign hold_sel = r.fwdctl[itwc_pkg::HOLD_MSB:itwc_pkg::HOLD_LSB];

  // forward decision
  assign match = r.fwdctl[itwc_pkg::PASS_ALL_BIT] ? (acc_id != ser_id)
               : ((acc_id == des_id) || (acc_id == rslave_id));

  itwc_osc_tick #(
    .DIV   (itwc_pkg::OSC_DIV)
  ) u_tick (
    .clk   (clk),
    .reset (reset),
    .tick  (osc_tick)
  );

  // ----------------------------------------------------------------------------
  // input filters
  // ----------------------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_filt
    itwc_glitch_filter #(
      .CNT_W (4)
    ) u_filt (
      .clk   (clk),
      .reset (reset),
      .din   (pin_raw[g]),
      .depth (filt_cyc),
      .dout  (pin_filt[g])
    );
  end

  // bit 0 carries scl, bit 1 sda
  assign pin_raw  = {sda_i, scl_i};
  assign scl_filt = pin_filt[0];
  assign sda_filt = pin_filt[1];

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    n           = r;
    n.rdata     = '0;
    n.abort     = 1'b0;
    n.fwd_valid = 1'b0;
    n.slv_done  = 1'b0;

    // first clock after reset release catches the strap
    if (!r.strap_done) begin
      n.strap_done = 1'b1;
      n.lvl        = ~level_strap_pin;
    end

    if (reg_wr) begin
      case (reg_addr)
        itwc_pkg::OFS_RESET_CTL: begin
          if (reg_wdata[itwc_pkg::DIG_RST0_BIT] || reg_wdata[itwc_pkg::DIG_RST1_BIT]) begin
            n.lvl = itwc_pkg::RST_LEVEL_3V3;
          end
        end
        itwc_pkg::OFS_LEVEL: begin
          if (reg_wdata == itwc_pkg::LEVEL_KEY) begin
            n.lvl = 1'b1;
          end else if (reg_wdata == itwc_pkg::LEVEL_CLEAR) begin
            n.lvl = 1'b0;
          end
        end
        itwc_pkg::OFS_WDOG:    n.wdctl = reg_wdata;
        itwc_pkg::OFS_FWD:     n.fwdctl = reg_wdata;
        itwc_pkg::OFS_SCL_HI:  n.hi = reg_wdata;
        itwc_pkg::OFS_SCL_LO:  n.lo = reg_wdata;
        itwc_pkg::OFS_IRQ_STS: n.sts = r.sts & ~reg_wdata[itwc_pkg::IRQ_W-1:0];
        itwc_pkg::OFS_IRQ_MSK: n.msk = reg_wdata[itwc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end

    if (reg_rd) begin
      case (reg_addr)
        itwc_pkg::OFS_LEVEL:   n.rdata = {7'h00, r.lvl};
        itwc_pkg::OFS_WDOG:    n.rdata = r.wdctl;
        itwc_pkg::OFS_FWD:     n.rdata = r.fwdctl;
        itwc_pkg::OFS_SCL_HI:  n.rdata = r.hi;
        itwc_pkg::OFS_SCL_LO:  n.rdata = r.lo;
        itwc_pkg::OFS_IRQ_STS: n.rdata = {6'h00, r.sts};
        itwc_pkg::OFS_IRQ_MSK: n.rdata = {6'h00, r.msk};
        default:               n.rdata = 8'h00;
      endcase
    end

    // watchdog runs only while a transaction is open and bit 0 is clear
    if (r.wdctl[itwc_pkg::WD_DIS_BIT] || !chan_busy) begin
      n.wd_cyc   = '0;
      n.wd_steps = 7'h00;
    end else if (r.wd_cyc == WDW'(WD_STEP_CYC - 1)) begin
      n.wd_cyc = '0;
      // a zero field times out after one step rather than never
      if (r.wd_steps + 7'h01 >= wd_tmo) begin
        n.abort    = 1'b1;
        n.wd_steps = 7'h00;
        n.sts[itwc_pkg::IRQ_WDOG_BIT] = 1'b1;
      end else begin
        n.wd_steps = r.wd_steps + 7'h01;
      end
    end else begin
      n.wd_cyc = r.wd_cyc + 1'b1;
    end

    if (acc_valid) begin
      n.fwd_valid = match;
      if (!match) begin
        n.sts[itwc_pkg::IRQ_DROP_BIT] = 1'b1;
      end
    end

    // scl generator, counts in oscillator ticks
    case (r.st)
      itwc_pkg::SCL_IDLE: begin
        n.cnt = 9'h000;
        if (mst_en) begin
          n.st = itwc_pkg::SCL_LOW;
        end else if (slv_setup_req) begin
          n.st = itwc_pkg::SCL_SETUP;
        end
      end
      itwc_pkg::SCL_LOW: begin
        if (osc_tick) begin
          n.cnt = r.cnt + 9'h001;
          if (r.cnt + 9'h001 == {1'b0, r.lo} + 9'(itwc_pkg::SCL_EXTRA_OSC)) begin
            n.st  = itwc_pkg::SCL_HIGH;
            n.cnt = 9'h000;
          end
        end
      end
      itwc_pkg::SCL_HIGH: begin
        if (osc_tick) begin
          n.cnt = r.cnt + 9'h001;
          if (r.cnt + 9'h001 == {1'b0, r.hi} + 9'(itwc_pkg::SCL_EXTRA_OSC)) begin
            n.st  = mst_en ? itwc_pkg::SCL_LOW : itwc_pkg::SCL_IDLE;
            n.cnt = 9'h000;
          end
        end
      end
      itwc_pkg::SCL_SETUP: begin
        if (r.cnt >= {1'b0, r.lo}) begin
          n.st       = itwc_pkg::SCL_IDLE;
          n.slv_done = 1'b1;
          n.cnt      = 9'h000;
        end else if (osc_tick) begin
          n.cnt = r.cnt + 9'h001;
        end
      end
      default: begin
        n.st  = itwc_pkg::SCL_IDLE;
        n.cnt = 9'h000;
      end
    endcase

    // an abort drops any clock phase so the next transaction starts clean
    if (n.abort) begin
      n.st  = itwc_pkg::SCL_IDLE;
      n.cnt = 9'h000;
    end

    n.len = (n.st != r.st) ? 12'h000 : r.len + 12'h001;

    // sda delay line, one tap group per 40 ns step
    n.sda_sr   = {r.sda_sr[TAPS-2:0], sda_filt};
    n.sda_hold = (hold_sel == 3'h0) ? sda_filt
               : r.sda_sr[int'(hold_sel) * itwc_pkg::HOLD_STEP_CYC - 1];
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r          <= '0;
      r.lvl      <= itwc_pkg::RST_LEVEL_3V3;
      r.wdctl    <= itwc_pkg::RST_WDOG;
      r.fwdctl   <= itwc_pkg::RST_FWD;
      r.hi       <= itwc_pkg::RST_SCL_HI;
      r.lo       <= itwc_pkg::RST_SCL_LO;
      r.st       <= itwc_pkg::SCL_IDLE;
      r.sda_sr   <= '1;
      r.sda_hold <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign reg_rdata      = r.rdata;
  assign irq            = |(r.sts & r.msk);
  assign level_sel_3v3  = r.lvl;
  assign chan_abort     = r.abort;
  assign fwd_valid      = r.fwd_valid;
  assign slv_setup_done = r.slv_done;
  // open-drain: only ever pulls low
  assign scl_o          = 1'b0;
  assign scl_oe         = (r.st == itwc_pkg::SCL_LOW) || (r.st == itwc_pkg::SCL_SETUP);
  assign sda_held       = r.sda_hold;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  a_strap_latch: assert property (@(posedge clk) disable iff (reset)
    $rose(r.strap_done) |-> level_sel_3v3 == !$past(level_strap_pin))
    else $error("strap level not latched correctly");

  a_digital_reset: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == itwc_pkg::OFS_RESET_CTL && reg_wdata[1:0] != 2'b00 && r.strap_done)
    |=> level_sel_3v3)
    else $error("digital reset did not select 3.3 V");

  a_level_read: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == itwc_pkg::OFS_LEVEL) |=> reg_rdata == {7'h00, $past(level_sel_3v3)})
    else $error("level read does not show selection");

  a_key_write: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == itwc_pkg::OFS_LEVEL && reg_wdata == itwc_pkg::LEVEL_KEY && r.strap_done)
    |=> level_sel_3v3 ##1 reg_rdata == 8'h00 || level_sel_3v3)
    else $error("key write did not set level select");

  a_wd_timeout: assert property (@(posedge clk) disable iff (reset)
    chan_abort |-> $past(chan_busy) && $past(r.wd_cyc) == WDW'(WD_STEP_CYC - 1)
                   && $past(r.wd_steps) + 7'h01 >= $past(wd_tmo))
    else $error("watchdog abort without full timeout");

  a_wd_disable: assert property (@(posedge clk) disable iff (reset)
    $past(r.wdctl[itwc_pkg::WD_DIS_BIT]) |-> !chan_abort)
    else $error("disabled watchdog aborted");

  a_fwd_match: assert property (@(posedge clk) disable iff (reset)
    (acc_valid && !r.fwdctl[itwc_pkg::PASS_ALL_BIT] && acc_id != des_id && acc_id != rslave_id)
    |=> !fwd_valid && r.sts[itwc_pkg::IRQ_DROP_BIT])
    else $error("unmatched id forwarded");

  a_fwd_all: assert property (@(posedge clk) disable iff (reset)
    (acc_valid && r.fwdctl[itwc_pkg::PASS_ALL_BIT]) |=> fwd_valid == ($past(acc_id) != $past(ser_id)))
    else $error("pass-all forwarding wrong");

  a_scl_low_len: assert property (@(posedge clk) disable iff (reset)
    (r.st == itwc_pkg::SCL_LOW && n.st == itwc_pkg::SCL_HIGH)
    |-> int'(r.len) >= (int'(r.lo) + 4) * itwc_pkg::OSC_DIV
     && int'(r.len) < (int'(r.lo) + 5) * itwc_pkg::OSC_DIV)
    else $error("scl low time wrong");

  a_scl_high_len: assert property (@(posedge clk) disable iff (reset)
    (r.st == itwc_pkg::SCL_HIGH && n.st != itwc_pkg::SCL_HIGH && !n.abort)
    |-> int'(r.len) >= (int'(r.hi) + 4) * itwc_pkg::OSC_DIV
     && int'(r.len) < (int'(r.hi) + 5) * itwc_pkg::OSC_DIV)
    else $error("scl high time wrong");

  a_abort_idle: assert property (@(posedge clk) disable iff (reset)
    chan_abort |-> !scl_oe && r.st == itwc_pkg::SCL_IDLE)
    else $error("abort left scl active");

endmodule

// ---- hw/itwc_pkg.sv ----
// shared constants and types for the i2c timing and watchdog configuration block
package itwc_pkg;

  // ----------------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 8;
  localparam logic [7:0]  OFS_RESET_CTL = 8'h01;
  localparam logic [7:0]  OFS_LEVEL     = 8'h15;
  localparam logic [7:0]  OFS_WDOG      = 8'h16;
  localparam logic [7:0]  OFS_FWD       = 8'h17;
  localparam logic [7:0]  OFS_SCL_HI    = 8'h18;
  localparam logic [7:0]  OFS_SCL_LO    = 8'h19;
  localparam logic [7:0]  OFS_IRQ_STS   = 8'h30;
  localparam logic [7:0]  OFS_IRQ_MSK   = 8'h31;

  // ----------------------------------------------------------------------------
  // reset values and keys
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  RST_WDOG      = 8'hFE;
  localparam logic [7:0]  RST_FWD       = 8'h1E;
  localparam logic [7:0]  RST_SCL_HI    = 8'hA1;
  localparam logic [7:0]  RST_SCL_LO    = 8'hA5;
  localparam logic        RST_LEVEL_3V3 = 1'b1;
  localparam logic [7:0]  LEVEL_KEY     = 8'hB5;
  localparam logic [7:0]  LEVEL_CLEAR   = 8'h00;

  // ----------------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------------
  localparam int          DIG_RST0_BIT  = 0;
  localparam int          DIG_RST1_BIT  = 1;
  localparam int          WD_DIS_BIT    = 0;
  localparam int          WD_TMO_MSB    = 7;
  localparam int          WD_TMO_LSB    = 1;
  localparam int          PASS_ALL_BIT  = 7;
  localparam int          HOLD_MSB      = 6;
  localparam int          HOLD_LSB      = 4;
  localparam int          FILT_MSB      = 3;
  localparam int          FILT_LSB      = 0;
  localparam int          IRQ_W         = 2;
  localparam int          IRQ_WDOG_BIT  = 0;
  localparam int          IRQ_DROP_BIT  = 1;

  // ----------------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          OSC_PERIOD_NS = 40;
  localparam int          OSC_DIV       = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          SCL_EXTRA_OSC = 5;
  localparam int          WD_STEP_MS    = 2;
  localparam int          WD_STEP_CYC   = WD_STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          HOLD_STEP_NS  = 40;
  localparam int          HOLD_STEP_CYC = HOLD_STEP_NS / CLK_PERIOD_NS;
  localparam int          HOLD_MAX      = 7;
  localparam int          HOLD_TAPS     = HOLD_MAX * HOLD_STEP_CYC;
  localparam int          FILT_STEP_NS  = 5;

  // ----------------------------------------------------------------------------
  // clock generator states
  // ----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    SCL_IDLE  = 4'h1,
    SCL_LOW   = 4'h2,
    SCL_HIGH  = 4'h4,
    SCL_SETUP = 4'h8
  } itwc_scl_state_t;

endpackage

// ---- hw/itwc_osc_tick.sv ----
// oscillator-rate tick generator derived from the system clock
`timescale 1ns/100ps
module itwc_osc_tick #(
  parameter int DIV = itwc_pkg::OSC_DIV
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      tick
);

  // the counter is 8 bits wide, so the divider must fit in it
  if (DIV < 2 || DIV > 256) begin : g_bad_div
    $error("divider must be 2 to 256");
  end

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } itwc_tick_st_t;

  itwc_tick_st_t r;
  itwc_tick_st_t n;

  always_comb begin
    n      = r;
    n.tick = 1'b0;
    if (r.cnt == 8'(DIV - 1)) begin
      n.cnt  = 8'h00;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = r.tick;

endmodule

// ---- hw/itwc_glitch_filter.sv ----
// glitch filter: an input change must persist beyond depth cycles to pass
`timescale 1ns/100ps
module itwc_glitch_filter #(
  parameter int CNT_W = 4
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             din,
  input  wire logic [CNT_W-1:0] depth,
  output logic                  dout
);

  typedef struct packed {
    logic             q;
    logic [CNT_W-1:0] cnt;
  } itwc_filt_st_t;

  itwc_filt_st_t r;
  itwc_filt_st_t n;

  always_comb begin
    n = r;
    if (din == r.q) begin
      n.cnt = '0;
    end else if (r.cnt >= depth) begin
      n.q   = din;
      n.cnt = '0;
    end else begin
      n.cnt = r.cnt + 1'b1;
    end
  end

  // idle bus level is high, so the filter starts released
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r     <= '0;
      r.q   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign dout = r.q;

endmodule

// ---- testbench/itwc_bus_model.sv ----
// local i2c bus model: pulled-up scl wire and a slave shifting sda
`timescale 1ns/100ps
module itwc_bus_model (
  input  wire logic scl_o,
  input  wire logic scl_oe,
  input  wire logic pull_lo,
  output logic      scl_i,
  output logic      sda_i
);
  logic [7:0] pat_r;
  // open drain with pull-up: a released scl reads high; pull_lo is another master pulling it down
  assign scl_i = (scl_oe ? scl_o : 1'h1) & ~pull_lo;
  initial pat_r = 8'hA6;
  // data moves only while scl is low, never across a high phase
  always @(negedge scl_i) pat_r <= {pat_r[6:0], pat_r[7]};
  assign sda_i = pat_r[7];
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the i2c timing and watchdog block
`timescale 1ns/100ps
module testbench;
  logic       clk = 1'h0;
  logic       reset = 1'h1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic       reg_wr = 1'h0;
  logic       reg_rd = 1'h0;
  logic       irq, level_sel_3v3, chan_abort, fwd_valid, slv_setup_done;
  logic       level_strap_pin = 1'h0;
  logic       chan_busy = 1'h0;
  logic       acc_valid = 1'h0;
  logic [6:0] acc_id = 7'h00;
  logic [6:0] ser_id = 7'h10;
  logic [6:0] des_id = 7'h20;
  logic [6:0] rslave_id = 7'h30;
  logic       mst_en = 1'h0;
  logic       slv_setup_req = 1'h0;
  logic       pull_lo = 1'h0;
  logic       scl_i, sda_i, scl_o, scl_oe, scl_filt, sda_held;
  int         fails = 0;
  int         total_checks = 0;
  int         n;

  always #4 clk = ~clk;

  itwc_top #(.WD_STEP_CYC(4)) itwc_top_i (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .level_strap_pin, .level_sel_3v3, .chan_busy, .chan_abort, .acc_valid, .acc_id,
    .ser_id, .des_id, .rslave_id, .fwd_valid, .mst_en, .slv_setup_req, .slv_setup_done, .scl_i, .sda_i,
    .scl_o, .scl_oe, .scl_filt, .sda_held);
  itwc_bus_model itwc_bus_model_i (.scl_o, .scl_oe, .pull_lo, .scl_i, .sda_i);

  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic do_reset(input logic s);
    reset <= 1'h1;
    level_strap_pin <= s;
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic acc(input logic [6:0] id, input logic exp);
    @(posedge clk);
    acc_valid <= 1'h1;
    acc_id <= id;
    @(posedge clk);
    acc_valid <= 1'h0;
    #1 chk(fwd_valid, exp);
  endtask
  task automatic phase(input logic lvl);
    n = 0;
    while (scl_i === lvl && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  // pull scl low for w edges, counting over w + 12 cycles those in which the filtered scl is low
  task automatic pulse(input int w);
    @(posedge clk);
    pull_lo <= 1'h1;
    n = 0;
    for (int i = 0; i < w + 12; i++) begin
      @(posedge clk);
      if (i == w - 1) begin
        pull_lo <= 1'h0;
      end
      #1 n += int'(!scl_filt);
    end
  endtask
  // worst latency from an sda change to sda_held; each scl pulse makes the slave move sda
  task automatic hold_lat(input logic [7:0] cfg);
    int lat;
    wr(8'h17, cfg);
    repeat (20) @(posedge clk);
    lat = 0;
    repeat (8) begin
      @(posedge clk);
      pull_lo <= 1'h1;
      @(posedge clk);
      pull_lo <= 1'h0;
      #1 n = 1;
      while (sda_held !== sda_i && n < 40) begin
        @(posedge clk);
        #1 n++;
      end
      if (n > lat) begin
        lat = n;
      end
    end
    n = lat;
  endtask
  task automatic test_done;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset;
    do_reset(1'h1);
    rd(8'h15, 8'h00);
    chk(level_sel_3v3, 1'h0);
    wr(8'h01, 8'h02);
    rd(8'h15, 8'h01);
    do_reset(1'h0);
    rd(8'h15, 8'h01);
    rd(8'h16, 8'hFE);
    rd(8'h17, 8'h1E);
    rd(8'h18, 8'hA1);
    rd(8'h19, 8'hA5);
    rd(8'h31, 8'h00);
    rd(8'h40, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_level;
    wr(8'h15, 8'h00);
    rd(8'h15, 8'h00);
    wr(8'h15, 8'h33);
    rd(8'h15, 8'h00);
    wr(8'h15, 8'hB5);
    rd(8'h15, 8'h01);
    chk(level_sel_3v3, 1'h1);
    wr(8'h15, 8'h00);
    wr(8'h01, 8'h01);
    rd(8'h15, 8'h01);
    $display("test level done");
  endtask
  task automatic t_wdog;
    wr(8'h30, 8'hFF);
    wr(8'h31, 8'h01);
    // timeout field 2, never 0 from software
    wr(8'h16, 8'h04);
    // a slave setup interval is still open when the abort lands
    @(posedge clk);
    chan_busy <= 1'h1;
    slv_setup_req <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      slv_setup_req <= 1'h0;
      #1 n++;
    end while (chan_abort !== 1'h1 && n < 40);
    chk(n, 8'h08);
    chk(scl_oe, 1'h0);
    @(posedge clk);
    #1 chk(chan_abort, 1'h0);
    chk(irq, 1'h1);
    @(posedge clk);
    chan_busy <= 1'h0;
    rd(8'h30, 8'h01);
    wr(8'h30, 8'h01);
    #1 chk(irq, 1'h0);
    wr(8'h16, 8'h05);
    chan_busy <= 1'h1;
    n = 0;
    repeat (30) begin
      @(posedge clk);
      #1 n += chan_abort;
    end
    chk(n, 8'h00);
    @(posedge clk);
    chan_busy <= 1'h0;
    wr(8'h16, 8'hFE);
    $display("test watchdog done");
  endtask
  task automatic t_fwd;
    wr(8'h30, 8'hFF);
    acc(7'h20, 1'h1);
    acc(7'h30, 1'h1);
    acc(7'h45, 1'h0);
    rd(8'h30, 8'h02);
    wr(8'h17, 8'h9E);
    acc(7'h45, 1'h1);
    acc(7'h10, 1'h0);
    acc(7'h20, 1'h1);
    wr(8'h30, 8'h02);
    rd(8'h30, 8'h00);
    $display("test forward done");
  endtask
  task automatic t_scl;
    wr(8'h19, 8'h02);
    wr(8'h18, 8'h01);
    @(posedge clk);
    mst_en <= 1'h1;
    phase(1'h1);
    phase(1'h0);
    chk(n >= 31 && n <= 35, 1'h1);
    phase(1'h1);
    chk(n >= 26 && n <= 30, 1'h1);
    @(posedge clk);
    mst_en <= 1'h0;
    repeat (80) @(posedge clk);
    slv_setup_req <= 1'h1;
    @(posedge clk);
    slv_setup_req <= 1'h0;
    n = 1;
    while (slv_setup_done !== 1'h1 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n >= 6 && n <= 12, 1'h1);
    $display("test scl done");
  endtask
  task automatic t_filt;
    // depth field 8 is 40 ns, five whole cycles
    wr(8'h17, 8'h08);
    pulse(5);
    chk(8'(n), 8'h00);
    pulse(6);
    chk(8'(n), 8'h06);
    hold_lat(8'h00);
    chk(8'(n), 8'h02);
    hold_lat(8'h30);
    chk(8'(n), 8'(2 + 3 * itwc_pkg::HOLD_STEP_CYC));
    wr(8'h17, 8'h1E);
    $display("test filter done");
  endtask

  initial begin
    t_reset;
    t_level;
    t_wdog;
    t_fwd;
    t_scl;
    t_filt;
    test_done;
  end
  // the scenarios need well under 2000 cycles
  initial begin
    #100000;
    fails++;
    test_done;
  end
endmodule
